/* File: src/gpio_port_pkg.sv */
package gpio_port_pkg;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;
    localparam logic [11:0] ADDR_PORT_INDEX_A = 12'hfd0;
    localparam logic [11:0] ADDR_WINDOW_A = 12'hfd1;
    localparam logic [11:0] ADDR_INPUT_A = 12'hfd2;
    localparam logic [11:0] ADDR_OUTPUT_A = 12'hfd3;
    localparam logic [11:0] PORT_STRIDE = 12'h004;
    localparam logic [7:0] IDX_DIRECTION = 8'h01;
    localparam logic [7:0] IDX_ALTFUNC_EN = 8'h02;
    localparam logic [7:0] IDX_OPEN_DRAIN = 8'h03;
    localparam logic [7:0] IDX_HIGH_DRIVE = 8'h04;
    localparam logic [7:0] IDX_WAKE_EN = 8'h05;
    localparam logic [7:0] IDX_PULLUP = 8'h06;
    localparam logic [7:0] IDX_AFS_ONE = 8'h07;
    localparam logic [7:0] IDX_AFS_TWO = 8'h08;
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_D = 8'h01;
    localparam logic [7:0] RST_SMALL_A = 8'h04;
endpackage : gpio_port_pkg

/* File: src/gpio_port_subreg_config.sv */
module gpio_port_subreg_config
    import gpio_port_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter logic [NUM_PORTS*PORT_W-1:0] LINE_PRESENT = {NUM_PORTS*PORT_W{1'b1}}
) (
    input wire logic clk, // System clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [11:0] regAddr, // Register address
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    input wire logic [7:0] regWdata, // Write data
    output logic [7:0] regRdata_q, // Read data, valid cycle after read
    input wire logic stopMode, // Device is in stop mode
    input wire logic [NUM_PORTS*PORT_W-1:0] pinIn, // Pin levels
    output logic [NUM_PORTS*PORT_W-1:0] pinOut_q, // Pin output level
    output logic [NUM_PORTS*PORT_W-1:0] pinOe_q, // Pin driver enable
    output logic [NUM_PORTS*PORT_W-1:0] pullupEn_q, // Weak pull-up enable
    output logic [NUM_PORTS*PORT_W-1:0] highDrive_q, // High drive enable
    output logic [NUM_PORTS*PORT_W-1:0] altEn_q, // Line under alternate function
    output logic [NUM_PORTS*PORT_W-1:0] altSelOne_q, // Effective select set 1
    output logic [NUM_PORTS*PORT_W-1:0] altSelTwo_q, // Effective select set 2
    output logic stopRecovery // Combined recovery request, level
);
    import gpio_port_pkg::*;

    logic [NUM_PORTS*PORT_W-1:0] syncA_q;
    logic [NUM_PORTS*PORT_W-1:0] syncB_q;
    logic [NUM_PORTS*PORT_W-1:0] wakeEn;
    logic [NUM_PORTS*PORT_W-1:0] stopRef_q;
    logic [NUM_PORTS*PORT_W-1:0] stopLatch_q;
    logic [7:0] rdata_d [NUM_PORTS];
    logic [NUM_PORTS-1:0] rhit;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // Reset values differ only for port D and for port A of the small package
            localparam logic [11:0] BASE = 12'(PORT_STRIDE * p);
            localparam logic [7:0] PU_RST = (p == 3) ? RST_PORT_D :
                ((p == 0 && SMALL_PACKAGE) ? RST_SMALL_A : RST_ZERO);
            localparam logic [7:0] AFS2_RST = (p == 0 && SMALL_PACKAGE) ? RST_SMALL_A : RST_ZERO;
            localparam logic [7:0] AF_RST = PU_RST;
            localparam logic [7:0] OC_RST = (p == 3) ? RST_PORT_D : RST_ZERO;
            logic [7:0] index_q, dir_q, af_q, oc_q, hd_q, wake_q, pu_q, afs1_q, afs2_q, out_q;
            logic [7:0] inMask, drive, winData;
            logic wrIdx, wrWin, wrOut;
            assign wrIdx = regWrite && regAddr == ADDR_PORT_INDEX_A + BASE;
            assign wrWin = regWrite && regAddr == ADDR_WINDOW_A + BASE;
            assign wrOut = regWrite && regAddr == ADDR_OUTPUT_A + BASE;
            assign inMask = LINE_PRESENT[p*PORT_W +: PORT_W];

            // Index survives accesses so software can stream several window writes
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    index_q <= RST_ZERO;
                end else if (wrIdx) begin
                    index_q <= regWdata;
                end
            end

            // Each sub-register loads only when the window is written while the
            // index points at it; an index outside 01..08 writes nothing.
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    dir_q <= RST_DIRECTION;
                end else if (wrWin && index_q == IDX_DIRECTION) begin
                    dir_q <= regWdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    af_q <= AF_RST;
                end else if (wrWin && index_q == IDX_ALTFUNC_EN) begin
                    af_q <= regWdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    oc_q <= OC_RST;
                end else if (wrWin && index_q == IDX_OPEN_DRAIN) begin
                    oc_q <= regWdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    hd_q <= RST_ZERO;
                end else if (wrWin && index_q == IDX_HIGH_DRIVE) begin
                    hd_q <= regWdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    wake_q <= RST_ZERO;
                end else if (wrWin && index_q == IDX_WAKE_EN) begin
                    wake_q <= regWdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    pu_q <= PU_RST;
                end else if (wrWin && index_q == IDX_PULLUP) begin
                    pu_q <= regWdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    afs1_q <= RST_ZERO;
                end else if (wrWin && index_q == IDX_AFS_ONE) begin
                    afs1_q <= regWdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    afs2_q <= AFS2_RST;
                end else if (wrWin && index_q == IDX_AFS_TWO) begin
                    afs2_q <= regWdata;
                end
            end

            // Output data has its own address and is not reached through the window
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    out_q <= RST_ZERO;
                end else if (wrOut) begin
                    out_q <= regWdata;
                end
            end

            // Unused indices read as zero
            always_comb begin
                case (index_q)
                    IDX_DIRECTION: winData = dir_q;
                    IDX_ALTFUNC_EN: winData = af_q;
                    IDX_OPEN_DRAIN: winData = oc_q;
                    IDX_HIGH_DRIVE: winData = hd_q;
                    IDX_WAKE_EN: winData = wake_q;
                    IDX_PULLUP: winData = pu_q;
                    IDX_AFS_ONE: winData = afs1_q;
                    IDX_AFS_TWO: winData = afs2_q;
                    default: winData = RST_ZERO;
                endcase
            end

            // Read mux only; the registered copy below holds between reads
            always_comb begin
                rhit[p] = 1'b1;
                rdata_d[p] = RST_ZERO;
                if (regAddr == ADDR_PORT_INDEX_A + BASE) begin
                    rdata_d[p] = index_q;
                end else if (regAddr == ADDR_WINDOW_A + BASE) begin
                    rdata_d[p] = winData;
                end else if (regAddr == ADDR_INPUT_A + BASE) begin
                    rdata_d[p] = syncB_q[p*PORT_W +: PORT_W] & inMask;
                end else if (regAddr == ADDR_OUTPUT_A + BASE) begin
                    rdata_d[p] = out_q;
                end else begin
                    rhit[p] = 1'b0;
                end
            end

            // Alternate functions drive through altEn; GPIO drive only when not alternate
            assign drive = ~dir_q & ~af_q;
            assign wakeEn[p*PORT_W +: PORT_W] = wake_q;

            // Pads see only flop outputs, so decode glitches never reach a pin
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    pinOut_q[p*PORT_W +: PORT_W] <= RST_ZERO;
                end else begin
                    pinOut_q[p*PORT_W +: PORT_W] <= out_q;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    pinOe_q[p*PORT_W +: PORT_W] <= RST_ZERO;
                end else begin
                    pinOe_q[p*PORT_W +: PORT_W] <= drive & ~(oc_q & out_q);
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    pullupEn_q[p*PORT_W +: PORT_W] <= RST_ZERO;
                end else begin
                    pullupEn_q[p*PORT_W +: PORT_W] <= pu_q;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    highDrive_q[p*PORT_W +: PORT_W] <= RST_ZERO;
                end else begin
                    highDrive_q[p*PORT_W +: PORT_W] <= hd_q;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    altEn_q[p*PORT_W +: PORT_W] <= RST_ZERO;
                end else begin
                    altEn_q[p*PORT_W +: PORT_W] <= af_q;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    altSelOne_q[p*PORT_W +: PORT_W] <= RST_ZERO;
                end else begin
                    altSelOne_q[p*PORT_W +: PORT_W] <= afs1_q & af_q;
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    altSelTwo_q[p*PORT_W +: PORT_W] <= RST_ZERO;
                end else begin
                    altSelTwo_q[p*PORT_W +: PORT_W] <= afs2_q & af_q;
                end
            end
        end
    endgenerate

    // Two stages to the system clock before the input read and the stop reference
    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncA_q <= '0;
        end else begin
            syncA_q <= pinIn;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncB_q <= '0;
        end else begin
            syncB_q <= syncA_q;
        end
    end

    // Reference follows the synchronised pins while running and freezes in stop;
    // in stop the clock may halt, so the compare below needs no edge.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stopRef_q <= '0;
        end else begin
            stopRef_q <= stopMode ? stopRef_q : syncB_q;
        end
    end

    // Holds a short wake pulse while the clock still runs; it samples raw pins
    // on purpose, as a late edge only delays the hold by one cycle.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stopLatch_q <= '0;
        end else begin
            stopLatch_q <= stopMode ? (stopLatch_q | (pinIn ^ stopRef_q) & wakeEn) : '0;
        end
    end

    // Raw pins feed this async request; a glitch can wake the part, which is harmless
    assign stopRecovery = stopMode && |(((pinIn ^ stopRef_q) & wakeEn) | stopLatch_q);

    // Port address ranges never overlap, so at most one port hits
    always_ff @(posedge clk) begin
        if (!resetn) begin
            regRdata_q <= RST_ZERO;
        end else if (regRead) begin
            regRdata_q <= RST_ZERO;
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (rhit[i]) begin
                    regRdata_q <= rdata_d[i];
                end
            end
        end
    end
endmodule : gpio_port_subreg_config

/* File: verif/gpio_port_subreg_config_asserts.sv */
module gpio_port_subreg_config_asserts
    import gpio_port_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic resetn, // Reset, active low
    input wire logic [11:0] regAddr, // Address
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    input wire logic [7:0] regRdata_q, // Read data
    input wire logic stopMode, // Stop mode
    input wire logic [NUM_PORTS*PORT_W-1:0] pinOe_q, // Driver enable
    input wire logic [NUM_PORTS*PORT_W-1:0] altEn_q, // Alternate enable
    input wire logic [NUM_PORTS*PORT_W-1:0] altSelOne_q, // Select set 1
    input wire logic stopRecovery // Recovery request
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_oe_not_alt: assert property ((pinOe_q & altEn_q) == '0)
        else $error("driver on alternate line");
    a_sel_masked: assert property ((altSelOne_q & ~altEn_q) == '0)
        else $error("select bit without alternate enable");
    a_recovery_in_stop: assert property (stopRecovery |-> stopMode)
        else $error("recovery outside stop mode");
    a_recovery_held: assert property (stopRecovery && stopMode |=> stopRecovery || !stopMode)
        else $error("recovery request dropped");
    a_rdata_holds: assert property ($past(resetn) && !$past(regRead) |-> $stable(regRdata_q))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (regRead && regAddr == 12'h000 |=> regRdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_reset_clear: assert property ($rose(resetn) |-> pinOe_q == '0 && altEn_q == '0)
        else $error("outputs not cleared by reset");
    a_oe_quiet: assert property ($past(resetn) && !$past(regWrite) && !$past(regWrite, 2)
        |-> $stable(pinOe_q))
        else $error("driver enable moved without write");
endmodule : gpio_port_subreg_config_asserts

bind gpio_port_subreg_config gpio_port_subreg_config_asserts u_chk (.clk, .resetn, .regAddr,
    .regWrite, .regRead, .regRdata_q, .stopMode, .pinOe_q, .altEn_q, .altSelOne_q, .stopRecovery);

/* File: verif/pin_partner.sv */
module pin_partner
    import gpio_port_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic [NUM_PORTS*PORT_W-1:0] pinOe_q, // Device drives
    input wire logic [NUM_PORTS*PORT_W-1:0] pinOut_q, // Device level
    input wire logic [NUM_PORTS*PORT_W-1:0] pullupEn_q, // Weak pull-up
    input wire logic [NUM_PORTS*PORT_W-1:0] extEn, // Board drives
    input wire logic [NUM_PORTS*PORT_W-1:0] extVal, // Board level
    output logic [NUM_PORTS*PORT_W-1:0] pinLvl // Line level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [NUM_PORTS*PORT_W-1:0] lastLvl_q = '0;
    // A floating line without pull-up flips each cycle so no settled value can hide a fault
    assign pinLvl = (pinOe_q & pinOut_q) | (~pinOe_q & extEn & extVal)
        | (~pinOe_q & ~extEn & (pullupEn_q | ~lastLvl_q));
    always @(posedge clk) begin
        lastLvl_q <= pinLvl;
    end
endmodule : pin_partner

/* File: verif/gpio_port_subreg_config_tb.sv */
module gpio_port_subreg_config_tb
    import gpio_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] PRESENT = 32'h0fffffff;
    logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, stopMode = 1'b0;
    logic [11:0] regAddr = '0;
    logic [7:0] regWdata = '0, regRdata_q;
    logic [31:0] pinIn, pinOut_q, pinOe_q, pullupEn_q, altEn_q, altSelOne_q, altSelTwo_q;
    logic [31:0] highDrive_q;
    logic [31:0] extEn = '1, extVal = '0;
    logic stopRecovery, rdDly = 1'b0;
    logic [7:0] expQ[$];
    int error_cnt = 0, compares = 0, cycles = 0;
    gpio_port_subreg_config #(.LINE_PRESENT(PRESENT)) u_dut (.clk, .resetn, .regAddr, .regWrite,
        .regRead, .regWdata, .regRdata_q, .stopMode, .pinIn, .pinOut_q, .pinOe_q, .pullupEn_q,
        .highDrive_q, .altEn_q, .altSelOne_q, .altSelTwo_q, .stopRecovery);
    pin_partner u_pins (.clk, .pinOe_q, .pinOut_q, .pullupEn_q, .extEn, .extVal, .pinLvl(pinIn));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic final_report();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // A read notes d as the expected data; a write sends d
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        if (!w) expQ.push_back(d);
        @(posedge clk);
        regWrite <= w;
        regRead <= ~w;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
    endtask : acc
    task automatic sub(input logic w, input int p, input logic [7:0] i, input logic [7:0] d);
        acc(1'b1, ADDR_PORT_INDEX_A + 12'(p) * PORT_STRIDE, i);
        acc(w, ADDR_WINDOW_A + 12'(p) * PORT_STRIDE, d);
    endtask : sub
    always @(posedge clk) begin
        if (rdDly) chk("read data", {24'h0, expQ.pop_front()}, {24'h0, regRdata_q});
        rdDly <= regRead;
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        logic [7:0] r;
        logic [11:0] b;
        void'($urandom(90));
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        acc(1'b0, 12'h000, 8'h00);
        for (int p = 0; p < NUM_PORTS; p++) begin
            b = 12'(p) * PORT_STRIDE;
            sub(1'b0, p, IDX_WAKE_EN, RST_ZERO);
            sub(1'b0, p, IDX_PULLUP, p == 3 ? RST_PORT_D : RST_ZERO);
            sub(1'b0, p, IDX_AFS_ONE, RST_ZERO);
            sub(1'b0, p, IDX_AFS_TWO, RST_ZERO);
            acc(1'b0, ADDR_OUTPUT_A + b, RST_ZERO);
            for (int i = 5; i < 9; i++) begin
                r = 8'($urandom);
                sub(1'b1, p, 8'(i), r);
                sub(1'b0, p, 8'(i), r);
            end
            r = 8'($urandom);
            acc(1'b1, ADDR_OUTPUT_A + b, r);
            acc(1'b0, ADDR_OUTPUT_A + b, r);
            sub(1'b1, p, 8'h09, 8'hff);
            sub(1'b0, p, 8'h09, 8'h00);
            sub(1'b1, p, IDX_WAKE_EN, p == 1 ? 8'h08 : 8'h00);
        end
        extVal <= $urandom;
        acc(1'b1, ADDR_INPUT_A, 8'h5a);
        for (int p = 0; p < NUM_PORTS; p++) begin
            b = 12'(p) * PORT_STRIDE;
            r = 8'((extVal & PRESENT) >> (8 * p));
            acc(1'b0, ADDR_INPUT_A + b, r);
        end
        sub(1'b1, 2, IDX_PULLUP, 8'hff);
        extEn <= 32'hff00ffff;
        repeat (3) @(posedge clk);
        chk("pull-up enable", 32'hff, (pullupEn_q >> 16) & 32'hff);
        acc(1'b0, ADDR_INPUT_A + 12'h2 * PORT_STRIDE, 8'hff);
        extEn <= '1;
        sub(1'b1, 0, IDX_DIRECTION, 8'h00);
        acc(1'b1, ADDR_OUTPUT_A, 8'ha5);
        repeat (3) @(posedge clk);
        chk("drive enable", 32'hff, pinOe_q & 32'hff);
        chk("output level", 32'ha5, pinOut_q & 32'hff);
        acc(1'b0, ADDR_INPUT_A, 8'ha5);
        sub(1'b1, 0, IDX_OPEN_DRAIN, 8'hff);
        sub(1'b1, 0, IDX_HIGH_DRIVE, 8'h81);
        repeat (3) @(posedge clk);
        chk("drive enable", 32'h5a, pinOe_q & 32'hff);
        chk("high drive", 32'h81, highDrive_q & 32'hff);
        sub(1'b0, 0, IDX_HIGH_DRIVE, 8'h81);
        sub(1'b1, 0, IDX_AFS_ONE, 8'hff);
        sub(1'b1, 0, IDX_AFS_TWO, 8'h3c);
        sub(1'b1, 0, IDX_ALTFUNC_EN, 8'h0f);
        repeat (3) @(posedge clk);
        chk("drive enable", 32'h50, pinOe_q & 32'hff);
        chk("alternate enable", 32'h0f, altEn_q & 32'hff);
        chk("select one", 32'h0f, altSelOne_q & 32'hff);
        chk("select two", 32'h0c, altSelTwo_q & 32'hff);
        extVal <= 32'h0;
        repeat (3) @(posedge clk);
        stopMode <= 1'b1;
        extVal <= 32'h100;
        repeat (3) @(posedge clk);
        chk("recovery", 32'h0, {31'h0, stopRecovery});
        extVal <= 32'h900;
        #1;
        chk("recovery", 32'h1, {31'h0, stopRecovery});
        @(posedge clk);
        extVal <= 32'h100;
        repeat (2) @(posedge clk);
        chk("recovery held", 32'h1, {31'h0, stopRecovery});
        stopMode <= 1'b0;
        @(posedge clk);
        #1;
        chk("recovery", 32'h0, {31'h0, stopRecovery});
        final_report();
    end
endmodule : gpio_port_subreg_config_tb
